// ==== cfnsc_defines.svh ====
`ifndef CFNSC_DEFINES_SVH
`define CFNSC_DEFINES_SVH
`define CFNSC_CFN_W 8
`define CFNSC_SFN_W 12
`define CFNSC_DOFF_W 10
`define CFNSC_CHIP_W 16
`define CFNSC_CHIPS_PER_FRAME 38400
`define CFNSC_DOFF_UNIT 512
`define CFNSC_CFN_RESET 8'h00
`define CFNSC_SFN_RESET 12'h000
`define CFNSC_SUBST_OFF 8'hff
`define CFNSC_SUBST_TM 16'hffff
`endif

// ==== cfnsc_pkg.sv ====
package cfnsc_pkg;
	typedef enum logic [3:0] {
		CFNSC_IDLE = 4'h1,
		CFNSC_COMMON = 4'h2,
		CFNSC_DEDIC = 4'h4,
		CFNSC_WAIT_SFN = 4'h8
	} cfnsc_state_type;
	typedef enum logic [3:0] {
		CFNSC_C_IDLE = 4'h1,
		CFNSC_C_PREP = 4'h2,
		CFNSC_C_ARMED = 4'h4,
		CFNSC_C_DONE = 4'h8
	} cfnsc_ctl_state_type;
endpackage

// ==== cfnsc_link_if.sv ====
`include "cfnsc_defines.svh"
interface cfnsc_link_if;
	logic frame_tick;
	logic [`CFNSC_SFN_W-1:0] sfn;
	logic tdd;
	logic enter_common;
	logic enter_dedic;
	logic several;
	logic from_other_ran;
	logic doff_valid;
	logic [`CFNSC_DOFF_W-1:0] doff;
	logic ho_start;
	logic target_measurable;
	logic [`CFNSC_SFN_W-1:0] sfn_target;
	logic fdd_to_tdd;
	logic meas_done;
	logic report_valid;
	logic [`CFNSC_CFN_W-1:0] report_off;
	logic [`CFNSC_CHIP_W-1:0] report_tm;
	logic report_tm_valid;
	logic change_valid;
	logic [`CFNSC_CFN_W-1:0] change_cfn;
	logic [`CFNSC_CFN_W-1:0] cfn;
	logic l1_switch;
	modport terminal (
		input frame_tick, sfn, tdd, enter_common, enter_dedic, several, from_other_ran, doff_valid, doff,
		input ho_start, target_measurable, sfn_target, fdd_to_tdd, meas_done, change_valid, change_cfn,
		output report_valid, report_off, report_tm, report_tm_valid, cfn, l1_switch
	);
	modport controller (
		output frame_tick, sfn, tdd, enter_common, enter_dedic, several, from_other_ran, doff_valid, doff,
		output ho_start, target_measurable, sfn_target, fdd_to_tdd, meas_done, change_valid, change_cfn,
		input report_valid, report_off, report_tm, report_tm_valid, cfn, l1_switch
	);
endinterface

// ==== cfnsc_offset_calc.sv ====
`include "cfnsc_defines.svh"
module cfnsc_offset_calc (
	// frame numbers in
	input wire logic [`CFNSC_SFN_W-1:0] i_sfn,
	input wire logic [`CFNSC_CFN_W-1:0] i_cfn,
	input wire logic [`CFNSC_DOFF_W-1:0] i_doff,
	input wire logic i_tdd,
	// results
	output logic [`CFNSC_CFN_W-1:0] o_init_cfn,
	output logic [`CFNSC_CFN_W-1:0] o_diff
);
	logic [31:0] chips;
	logic [31:0] quot;
	always_comb begin
		chips = 32'(i_sfn) * 32'(`CFNSC_CHIPS_PER_FRAME) - 32'(i_doff) * 32'(`CFNSC_DOFF_UNIT);
		quot = $unsigned($signed(chips) >>> 0);
		if (i_tdd) begin
			o_init_cfn = 8'(i_sfn - 12'(i_doff));
		end else begin
			// signed floor division keeps the wrap correct when doff pushes below zero
			quot = 32'($signed(chips) / $signed(32'(`CFNSC_CHIPS_PER_FRAME)));
			if ($signed(chips) < 0 && ($signed(chips) % $signed(32'(`CFNSC_CHIPS_PER_FRAME))) != 0) begin
				quot = quot - 32'h1;
			end
			o_init_cfn = quot[7:0];
		end
		o_diff = 8'(i_sfn) - i_cfn;
	end
endmodule // cfnsc_offset_calc

// ==== cfnsc_terminal.sv ====
`include "cfnsc_defines.svh"
module cfnsc_terminal (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// link
	cfnsc_link_if.terminal link,
	// user side
	output logic [`CFNSC_SFN_W-1:0] o_pch_cfn,
	output logic [`CFNSC_CFN_W-1:0] o_common_cfn,
	output logic o_dedicated
);
	cfnsc_pkg::cfnsc_state_type state, next_state;
	logic [`CFNSC_CFN_W-1:0] cfn, next_cfn;
	logic [`CFNSC_CFN_W-1:0] common_cfn, next_common_cfn;
	logic [`CFNSC_SFN_W-1:0] pch_cfn, next_pch_cfn;
	logic [`CFNSC_DOFF_W-1:0] doff, next_doff;
	logic pend_init, next_pend_init;
	logic report_valid, next_report_valid;
	logic [`CFNSC_CFN_W-1:0] report_off, next_report_off;
	logic [`CFNSC_CHIP_W-1:0] report_tm, next_report_tm;
	logic report_tm_valid, next_report_tm_valid;
	logic l1_pend, next_l1_pend;
	logic [`CFNSC_CFN_W-1:0] l1_cfn, next_l1_cfn;
	logic l1_switch, next_l1_switch;
	logic [`CFNSC_CFN_W-1:0] init_cur, init_tgt, diff_tgt;

	cfnsc_offset_calc calc_cur (
		.i_sfn(link.sfn),
		.i_cfn(cfn),
		.i_doff(doff),
		.i_tdd(link.tdd),
		.o_init_cfn(init_cur),
		.o_diff()
	);
	cfnsc_offset_calc calc_tgt (
		.i_sfn(link.sfn_target),
		.i_cfn(cfn),
		.i_doff(doff),
		.i_tdd(link.tdd),
		.o_init_cfn(init_tgt),
		.o_diff(diff_tgt)
	);

	always_comb begin
		next_state = state;
		next_cfn = cfn;
		next_common_cfn = common_cfn;
		next_pch_cfn = pch_cfn;
		next_doff = doff;
		next_pend_init = pend_init;
		next_report_valid = 1'b0;
		next_report_off = report_off;
		next_report_tm = report_tm;
		next_report_tm_valid = report_tm_valid;
		next_l1_pend = l1_pend;
		next_l1_cfn = l1_cfn;
		next_l1_switch = 1'b0;

		// latch a new default offset
		if (link.doff_valid) begin
			next_doff = link.doff;
			if (state == cfnsc_pkg::CFNSC_DEDIC) begin
				next_pend_init = 1'b1;
			end
		end

		// frame boundary advance
		if (link.frame_tick) begin
			next_pch_cfn = pch_cfn + 12'h001;
			next_common_cfn = common_cfn + 8'h01;
			next_cfn = cfn + 8'h01;
			if (l1_pend && cfn + 8'h01 == l1_cfn) begin
				next_l1_switch = 1'b1;
				next_l1_pend = 1'b0;
			end
		end

		// a change signalled in the switch cycle stays pending
		if (link.change_valid) begin
			next_l1_pend = 1'b1;
			next_l1_cfn = link.change_cfn;
		end

		// handover and several-link measurement and report
		if (link.ho_start || (link.several && link.frame_tick && state == cfnsc_pkg::CFNSC_COMMON)) begin
			next_report_valid = 1'b1;
			if (link.ho_start && !link.target_measurable) begin
				next_report_off = `CFNSC_SUBST_OFF;
				next_report_tm = `CFNSC_SUBST_TM;
			end else begin
				next_report_off = diff_tgt;
				next_report_tm = 16'h0000;
			end
			next_report_tm_valid = !link.tdd && !link.fdd_to_tdd;
		end

		// state transitions
		unique case (state)
			cfnsc_pkg::CFNSC_IDLE: begin
				if (link.enter_common) begin
					next_state = cfnsc_pkg::CFNSC_COMMON;
				end
			end
			cfnsc_pkg::CFNSC_COMMON: begin
				if (link.enter_dedic && (!link.several || link.meas_done)) begin
					next_state = cfnsc_pkg::CFNSC_DEDIC;
					if (link.tdd && link.from_other_ran) begin
						next_cfn = 8'(link.sfn);
					end else begin
						next_cfn = init_cur;
					end
				end
			end
			cfnsc_pkg::CFNSC_DEDIC: begin
				if (link.enter_common) begin
					next_state = cfnsc_pkg::CFNSC_COMMON;
				// an offset sent along with the handover counts as pending
				end else if (link.ho_start && (pend_init || link.doff_valid)) begin
					next_state = cfnsc_pkg::CFNSC_WAIT_SFN;
				end
				// without a new offset the CFN simply keeps counting
			end
			cfnsc_pkg::CFNSC_WAIT_SFN: begin
				if (link.target_measurable && link.frame_tick) begin
					next_cfn = init_tgt;
					next_pend_init = 1'b0;
					next_state = cfnsc_pkg::CFNSC_DEDIC;
				end
			end
			default: begin
				next_state = cfnsc_pkg::CFNSC_IDLE;
			end
		endcase

		// common state entry reloads
		if (link.enter_common) begin
			next_pch_cfn = link.sfn;
			next_common_cfn = 8'(link.sfn);
			next_pend_init = 1'b0;
		end
	end

	// state and counter registers
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state <= cfnsc_pkg::CFNSC_IDLE;
			cfn <= `CFNSC_CFN_RESET;
			common_cfn <= `CFNSC_CFN_RESET;
			pch_cfn <= `CFNSC_SFN_RESET;
			doff <= '0;
			pend_init <= 1'b0;
			report_valid <= 1'b0;
			report_off <= '0;
			report_tm <= '0;
			report_tm_valid <= 1'b0;
			l1_pend <= 1'b0;
			l1_cfn <= '0;
			l1_switch <= 1'b0;
		end else begin
			state <= next_state;
			cfn <= next_cfn;
			common_cfn <= next_common_cfn;
			pch_cfn <= next_pch_cfn;
			doff <= next_doff;
			pend_init <= next_pend_init;
			report_valid <= next_report_valid;
			report_off <= next_report_off;
			report_tm <= next_report_tm;
			report_tm_valid <= next_report_tm_valid;
			l1_pend <= next_l1_pend;
			l1_cfn <= next_l1_cfn;
			l1_switch <= next_l1_switch;
		end
	end

	// link and user outputs
	assign link.cfn = cfn;
	assign link.report_valid = report_valid;
	assign link.report_off = report_off;
	assign link.report_tm = report_tm;
	assign link.report_tm_valid = report_tm_valid;
	assign link.l1_switch = l1_switch;
	assign o_pch_cfn = pch_cfn;
	assign o_common_cfn = common_cfn;
	assign o_dedicated = (state == cfnsc_pkg::CFNSC_DEDIC) || (state == cfnsc_pkg::CFNSC_WAIT_SFN);
endmodule // cfnsc_terminal

// ==== cfnsc_controller.sv ====
`include "cfnsc_defines.svh"
module cfnsc_controller (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// link
	cfnsc_link_if.controller link,
	// frame timing and mode
	input wire logic i_frame_tick,
	input wire logic [`CFNSC_SFN_W-1:0] i_sfn,
	input wire logic [`CFNSC_SFN_W-1:0] i_sfn_target,
	input wire logic i_tdd,
	input wire logic i_several,
	input wire logic i_from_other_ran,
	input wire logic i_target_measurable,
	input wire logic i_fdd_to_tdd,
	input wire logic i_meas_done,
	// commands
	input wire logic i_enter_common,
	input wire logic i_enter_dedic,
	input wire logic i_ho_start,
	input wire logic [`CFNSC_DOFF_W-1:0] i_doff,
	input wire logic i_off_known,
	input wire logic i_sfn_diff_known,
	input wire logic i_cells_synced,
	input wire logic [`CFNSC_CFN_W-1:0] i_off_source,
	input wire logic [`CFNSC_CFN_W-1:0] i_sfn_diff,
	input wire logic i_change_req,
	input wire logic i_prep_done,
	input wire logic [`CFNSC_CFN_W-1:0] i_change_cfn,
	// station side
	output logic [`CFNSC_CFN_W-1:0] o_frame_offset,
	output logic [`CFNSC_CHIP_W-1:0] o_chip_offset,
	output logic o_offset_valid,
	output logic o_prepare,
	output logic o_l1_switch,
	output logic [`CFNSC_CFN_W-1:0] o_cfn
);
	cfnsc_pkg::cfnsc_ctl_state_type cstate, next_cstate;
	logic [`CFNSC_CFN_W-1:0] frame_offset, next_frame_offset;
	logic [`CFNSC_CHIP_W-1:0] chip_offset, next_chip_offset;
	logic offset_valid, next_offset_valid;
	logic change_valid, next_change_valid;
	logic [`CFNSC_CFN_W-1:0] change_cfn, next_change_cfn;
	logic [31:0] chips;
	logic off_avail;

	always_comb begin
		next_cstate = cstate;
		next_frame_offset = frame_offset;
		next_chip_offset = chip_offset;
		next_offset_valid = 1'b0;
		next_change_valid = 1'b0;
		next_change_cfn = change_cfn;
		chips = 32'(i_doff) * 32'(`CFNSC_DOFF_UNIT);
		off_avail = i_off_known || i_sfn_diff_known || (i_tdd && i_cells_synced);
		if (i_enter_dedic || i_ho_start) begin
			next_offset_valid = 1'b1;
			if (i_tdd) begin
				next_chip_offset = 16'h0000;
				if (i_enter_dedic && i_from_other_ran) begin
					next_frame_offset = 8'h00;
				end else if (i_ho_start && i_cells_synced) begin
					next_frame_offset = i_off_source;
				end else if (i_ho_start && i_sfn_diff_known) begin
					next_frame_offset = i_off_source + i_sfn_diff;
				end else if (i_ho_start && link.report_valid && link.report_off != `CFNSC_SUBST_OFF) begin
					next_frame_offset = link.report_off;
				end else begin
					next_frame_offset = 8'(i_doff);
				end
			end else if (i_ho_start && i_sfn_diff_known) begin
				next_frame_offset = i_off_source + i_sfn_diff;
				next_chip_offset = 16'(chips % 32'(`CFNSC_CHIPS_PER_FRAME));
			end else begin
				// reported values are ignored when the target offset is unknown
				next_frame_offset = 8'(chips / 32'(`CFNSC_CHIPS_PER_FRAME));
				next_chip_offset = 16'(chips % 32'(`CFNSC_CHIPS_PER_FRAME));
			end
		end
		unique case (cstate)
			cfnsc_pkg::CFNSC_C_IDLE: begin
				if (i_change_req) begin
					next_cstate = cfnsc_pkg::CFNSC_C_PREP;
				end
			end
			cfnsc_pkg::CFNSC_C_PREP: begin
				if (i_prep_done) begin
					next_change_cfn = i_change_cfn;
					next_change_valid = 1'b1;
					next_cstate = cfnsc_pkg::CFNSC_C_ARMED;
				end
			end
			cfnsc_pkg::CFNSC_C_ARMED: begin
				if (i_frame_tick && link.cfn + 8'h01 == change_cfn) begin
					next_cstate = cfnsc_pkg::CFNSC_C_DONE;
				end
			end
			cfnsc_pkg::CFNSC_C_DONE: begin
				next_cstate = cfnsc_pkg::CFNSC_C_IDLE;
			end
			default: begin
				next_cstate = cfnsc_pkg::CFNSC_C_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			cstate <= cfnsc_pkg::CFNSC_C_IDLE;
			frame_offset <= '0;
			chip_offset <= '0;
			offset_valid <= 1'b0;
			change_valid <= 1'b0;
			change_cfn <= '0;
		end else begin
			cstate <= next_cstate;
			frame_offset <= next_frame_offset;
			chip_offset <= next_chip_offset;
			offset_valid <= next_offset_valid;
			change_valid <= next_change_valid;
			change_cfn <= next_change_cfn;
		end
	end

	assign link.frame_tick = i_frame_tick;
	assign link.sfn = i_sfn;
	assign link.sfn_target = i_sfn_target;
	assign link.tdd = i_tdd;
	assign link.several = i_several;
	assign link.from_other_ran = i_from_other_ran;
	assign link.target_measurable = i_target_measurable;
	assign link.fdd_to_tdd = i_fdd_to_tdd;
	assign link.meas_done = i_meas_done;
	assign link.enter_common = i_enter_common;
	assign link.enter_dedic = i_enter_dedic;
	assign link.ho_start = i_ho_start;
	assign link.doff = i_doff;
	assign link.doff_valid = (i_enter_dedic || i_ho_start) && !off_avail;
	assign link.change_valid = change_valid;
	assign link.change_cfn = change_cfn;
	assign o_frame_offset = frame_offset;
	assign o_chip_offset = chip_offset;
	assign o_offset_valid = offset_valid;
	assign o_prepare = (cstate == cfnsc_pkg::CFNSC_C_PREP);
	assign o_l1_switch = link.l1_switch;
	assign o_cfn = link.cfn;
endmodule // cfnsc_controller

// ==== cfnsc_link_chk.sv ====
`include "cfnsc_defines.svh"
module cfnsc_link_chk (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// controller to terminal
	input wire logic frame_tick,
	input wire logic [11:0] sfn,
	input wire logic tdd,
	input wire logic enter_dedic,
	input wire logic from_other_ran,
	input wire logic doff_valid,
	input wire logic [9:0] doff,
	input wire logic ho_start,
	input wire logic target_measurable,
	input wire logic [11:0] sfn_target,
	input wire logic fdd_to_tdd,
	input wire logic change_valid,
	input wire logic [7:0] change_cfn,
	// terminal to controller
	input wire logic report_valid,
	input wire logic [7:0] report_off,
	input wire logic [15:0] report_tm,
	input wire logic report_tm_valid,
	input wire logic [7:0] cfn,
	input wire logic l1_switch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] lat_doff, next_lat_doff;
	logic [7:0] lat_chg, next_lat_chg;
	always_comb begin
		next_lat_doff = doff_valid ? doff : lat_doff;
		next_lat_chg = change_valid ? change_cfn : lat_chg;
	end
	always_ff @(posedge i_clock) begin
		lat_doff <= i_resetn ? next_lat_doff : 10'h000;
		lat_chg <= i_resetn ? next_lat_chg : 8'h00;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	property p_cfn_step;
		frame_tick && !enter_dedic && !ho_start && !target_measurable |=> cfn == $past(cfn) + 8'h01;
	endproperty
	a_cfn_step: assert property (p_cfn_step) else $error("cfn did not step");
	property p_tdd_init;
		enter_dedic && tdd && !from_other_ran && !frame_tick |=> cfn == 8'($past(sfn) - $past(lat_doff));
	endproperty
	a_tdd_init: assert property (p_tdd_init) else $error("bad tdd init");
	property p_rep_valid;
		ho_start |=> report_valid;
	endproperty
	a_rep_valid: assert property (p_rep_valid) else $error("no report");
	property p_rep_tm;
		ho_start |=> report_tm_valid == (!$past(tdd) && !$past(fdd_to_tdd));
	endproperty
	a_rep_tm: assert property (p_rep_tm) else $error("bad tm valid");
	property p_rep_subst;
		ho_start && !target_measurable |=> report_off == `CFNSC_SUBST_OFF && report_tm == `CFNSC_SUBST_TM;
	endproperty
	a_rep_subst: assert property (p_rep_subst) else $error("bad substitute");
	property p_rep_meas;
		ho_start && target_measurable |=> report_off == 8'($past(sfn_target) - $past(cfn));
	endproperty
	a_rep_meas: assert property (p_rep_meas) else $error("bad offset report");
	property p_keep;
		ho_start && !doff_valid && !frame_tick |=> $stable(cfn);
	endproperty
	a_keep: assert property (p_keep) else $error("cfn moved");
	property p_switch;
		l1_switch |-> $past(frame_tick) && cfn == lat_chg;
	endproperty
	a_switch: assert property (p_switch) else $error("bad switch");
endmodule // cfnsc_link_chk

// ==== testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock, i_resetn;
	logic tick, tdd, sev, oran, meas, f2t, mdone, ecom, eded, ho, okn, dkn, syn, creq, pdone, wt;
	logic ov, prep, l1sw, ded;
	logic [11:0] sfn, sfnt, pch;
	logic [9:0] doff, lat;
	logic [7:0] osrc, sdiff, ccfn, fo, ocfn, ccom, e;
	logic [15:0] co;
	int mismatches, checks;
	cfnsc_link_if cfnsc_link_if_i();
	cfnsc_terminal cfnsc_terminal_i(.i_clock(i_clock), .i_resetn(i_resetn), .link(cfnsc_link_if_i),
		.o_pch_cfn(pch), .o_common_cfn(ccom), .o_dedicated(ded));
	cfnsc_controller cfnsc_controller_i(.i_clock(i_clock), .i_resetn(i_resetn), .link(cfnsc_link_if_i),
		.i_frame_tick(tick), .i_sfn(sfn), .i_sfn_target(sfnt), .i_tdd(tdd), .i_several(sev),
		.i_from_other_ran(oran), .i_target_measurable(meas), .i_fdd_to_tdd(f2t), .i_meas_done(mdone),
		.i_enter_common(ecom), .i_enter_dedic(eded), .i_ho_start(ho), .i_doff(doff), .i_off_known(okn),
		.i_sfn_diff_known(dkn), .i_cells_synced(syn), .i_off_source(osrc), .i_sfn_diff(sdiff),
		.i_change_req(creq), .i_prep_done(pdone), .i_change_cfn(ccfn), .o_frame_offset(fo),
		.o_chip_offset(co), .o_offset_valid(ov), .o_prepare(prep), .o_l1_switch(l1sw), .o_cfn(ocfn));
	cfnsc_link_chk cfnsc_link_chk_i(.i_clock(i_clock), .i_resetn(i_resetn),
		.frame_tick(cfnsc_link_if_i.frame_tick), .sfn(cfnsc_link_if_i.sfn), .tdd(cfnsc_link_if_i.tdd),
		.enter_dedic(cfnsc_link_if_i.enter_dedic), .from_other_ran(cfnsc_link_if_i.from_other_ran),
		.doff_valid(cfnsc_link_if_i.doff_valid), .doff(cfnsc_link_if_i.doff),
		.ho_start(cfnsc_link_if_i.ho_start), .target_measurable(cfnsc_link_if_i.target_measurable),
		.sfn_target(cfnsc_link_if_i.sfn_target), .fdd_to_tdd(cfnsc_link_if_i.fdd_to_tdd),
		.change_valid(cfnsc_link_if_i.change_valid), .change_cfn(cfnsc_link_if_i.change_cfn),
		.report_valid(cfnsc_link_if_i.report_valid), .report_off(cfnsc_link_if_i.report_off),
		.report_tm(cfnsc_link_if_i.report_tm), .report_tm_valid(cfnsc_link_if_i.report_tm_valid),
		.cfn(cfnsc_link_if_i.cfn), .l1_switch(cfnsc_link_if_i.l1_switch));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	function automatic logic [7:0] init_cfn(logic [11:0] s, logic [9:0] d);
		return tdd ? 8'(s - 12'(d)) : 8'(int'(s) - (int'(d) * 512 + 38399) / 38400);
	endfunction
	function automatic logic [7:0] exp_frame();
		if (tdd) begin
			return oran ? 8'h00 : syn ? osrc : dkn ? 8'(osrc + sdiff) : doff[7:0];
		end
		return dkn ? 8'(osrc + sdiff) : 8'(int'(doff) * 512 / 38400);
	endfunction
	task automatic cmp_val(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t value %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(logic got, logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t flag %b exp %b", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge i_clock);
		s = 1'b1;
		@(negedge i_clock);
		s = 1'b0;
	endtask
	task automatic step();
		@(negedge i_clock);
		tick = 1'b1;
		@(negedge i_clock);
		tick = 1'b0;
		sfn++;
		if (wt && meas) begin
			e = init_cfn(sfnt, lat);
			wt = 1'b0;
		end else begin
			e++;
		end
	endtask
	task automatic handover(int c);
		logic dv;
		okn = c == 1;
		dkn = c == 2;
		syn = c == 3;
		osrc = 8'($urandom);
		sdiff = 8'($urandom);
		sfnt = 12'($urandom);
		meas = 1'($urandom);
		f2t = 1'($urandom);
		dv = !(okn || dkn || (tdd && syn));
		pulse(ho);
		if (!okn) cmp_val(fo, exp_frame());
		if (!okn && !dkn) cmp_val(co, tdd ? 16'h0000 : 16'(int'(doff) * 512 % 38400));
		cmp_flag(ov, 1'b1);
		cmp_val(ocfn, e);
		if (dv) begin
			lat = doff;
			wt = 1'b1;
		end
		meas = 1'b1;
		step();
		cmp_val(ocfn, e);
		meas = 1'b0;
	endtask
	initial begin
		repeat (20000) @(negedge i_clock);
		mismatches++;
		finish_test();
	end
	initial begin
		{tick, tdd, sev, oran, meas, f2t, mdone, ecom, eded, ho, okn, dkn, syn, creq, pdone, wt} = '0;
		{sfn, sfnt, doff, lat, osrc, sdiff, ccfn, e} = '0;
		mismatches = 0;
		checks = 0;
		i_resetn = 1'b0;
		repeat (8) @(negedge i_clock);
		i_resetn = 1'b1;
		void'($urandom(67195));
		for (int m = 0; m < 2; m++) begin
			for (int r = 0; r < 4; r++) begin
				{okn, dkn, syn} = '0;
				tdd = 1'(m);
				sfn = r == 0 ? 12'hffe : 12'($urandom);
				doff = r == 1 ? 10'h3ff : 10'($urandom);
				oran = tdd && r[0];
				sev = !tdd;
				mdone = 1'b0;
				pulse(ecom);
				cmp_val(pch, sfn);
				cmp_val(ccom, sfn[7:0]);
				repeat (3) step();
				cmp_val(pch, sfn);
				cmp_val(ccom, sfn[7:0]);
				if (sev) begin
					pulse(eded);
					lat = doff;
					cmp_flag(ded, 1'b0);
					mdone = 1'b1;
				end
				e = oran ? sfn[7:0] : init_cfn(sfn, lat);
				pulse(eded);
				cmp_val(fo, exp_frame());
				lat = doff;
				cmp_val(ocfn, e);
				cmp_flag(ded, 1'b1);
				oran = 1'b0;
				repeat (2) step();
				cmp_val(ocfn, e);
				if (tdd) cmp_val(ccom, sfn[7:0]);
				for (int c = 0; c < 4; c++) handover(c);
				ccfn = e + 8'(1 + $urandom % 3);
				pulse(creq);
				cmp_flag(prep, 1'b1);
				pulse(pdone);
				@(negedge i_clock);
				repeat (4) begin
					step();
					cmp_flag(l1sw, e == ccfn);
				end
			end
		end
		finish_test();
	end
endmodule // testbench
